// File: hw/rcm_defs.svh
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH

// =====================================================================
// register offsets
`define RCM_REG_CTRL      8'h00
`define RCM_REG_STATIC    8'h04
`define RCM_REG_SCALE     8'h08
`define RCM_REG_WARN_PCT  8'h0c
`define RCM_REG_TMIN      8'h10
`define RCM_REG_NSTEPS    8'h14
`define RCM_REG_FLAGS     8'h18
`define RCM_REG_LIMIT     8'h1c
`define RCM_REG_WARN_THR  8'h20
`define RCM_REG_IRQ_STAT  8'h24
`define RCM_REG_IRQ_MASK  8'h28
`define RCM_REG_ACK       8'h2c
`define RCM_REG_STEP_THR  8'h40
`define RCM_REG_STEP_OFS  8'h80

// =====================================================================
// sizes and field positions
`define RCM_NUM_STEPS     10
`define RCM_NSTEP_W       4
`define RCM_SEL_W         6
`define RCM_CTRL_MODE_LO  0
`define RCM_CTRL_SEL_LO   4
`define RCM_CTRL_BRK_EN   12
`define RCM_CTRL_BRK_CH_LO 16
`define RCM_NUM_MF        4
`define RCM_IRQ_W         5
`define RCM_ALARM_TMIN_RST 32'h0000_0019

`endif

// File: hw/rcm_monitor.sv
// Notes on behaviour
// - limit from static, dynamic or stepwise mode, chosen by software
// - static mode: limit is a constant; current above it is a violation
// - dynamic mode: limit is reference times scale plus static offset
// - stepwise mode: up to ten ascending reference thresholds with offsets
// - stepwise limit: static offset plus offset of highest exceeded step
// - stepwise with no thresholds configured: just the static offset
// - step offsets may fall as threshold rises; no ordering enforced
// - reference chosen among multifunction, basic and module channels
// - warning threshold is a configured percentage of the active limit
// - warning flag set when current rises above warning threshold
// - overcurrent flag set when current rises above the limit
// - alarm set only after exceedance lasts longer than minimum time
// - overcurrent flag clears once current is back at or below limit
// - warning flag clears once current is back at or below warning
// - alarm stays set until acknowledged by the operator side
// - optional cable break check on multifunction transformer inputs
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defs.svh"

module rcm_monitor
    import rcm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic [31:0] rc_value,
    input  wire logic        rc_valid,
    input  wire logic [63:0][15:0] ref_values,
    input  wire logic        ref_valid,
    input  wire logic [3:0]  mf_open,
    input  wire logic        ack_pulse,
    output logic             warn_flag,
    output logic             over_flag,
    output logic             alarm_flag,
    output logic             brk_flag,
    output logic             irq
);

    // =================================================================
    // state
    rcm_state_t s_q;
    rcm_state_t s_d;

    logic [3:0] mf_open_m_q;
    logic [3:0] mf_open_s_q;

    // =================================================================
    // pin synchroniser for the transformer open-circuit detectors
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mf_open_m_q <= 4'h0;
            mf_open_s_q <= 4'h0;
        end
        else
        begin
            mf_open_m_q <= mf_open;
            mf_open_s_q <= mf_open_m_q;
        end
    end

    // =================================================================
    // limit computation helpers
    logic [15:0] ref_now;
    logic [47:0] dyn_prod;
    logic [31:0] step_add;
    logic [9:0]  step_hit;
    logic [39:0] warn_prod;
    logic [31:0] lim_new;
    logic [31:0] warn_new;

    assign ref_now  = ref_values[s_q.ctrl.ref_sel];
    assign dyn_prod = {16'h0000, s_q.scale} * {32'h0000_0000, ref_now};

    genvar gi;
    generate
        for (gi = 0; gi < `RCM_NUM_STEPS; gi++)
        begin : g_step
            assign step_hit[gi] = (gi < s_q.nsteps) &&
                ({16'h0000, ref_now} > s_q.step_thresholds[gi]);
        end
    endgenerate

    always_comb
    begin
        step_add = 32'h0000_0000;
        for (int i = 0; i < `RCM_NUM_STEPS; i++)
        begin
            // offsets taken as given
            // later steps override earlier ones
            if (step_hit[i])
            begin
                step_add = s_q.step_offsets[i];
            end
        end
    end

    always_comb
    begin
        case (rcm_mode_t'(s_q.ctrl.mode))
            RCM_MODE_DYNAMIC:
                lim_new = s_q.static_offset + dyn_prod[31:0];
            RCM_MODE_STEPWISE:
                lim_new = s_q.static_offset + step_add;
            default:
                lim_new = s_q.static_offset;
        endcase
    end

    // warning threshold as percentage of limit
    assign warn_prod = {8'h00, lim_new} * {32'h0000_0000, s_q.warn_pct};
    assign warn_new  = 32'((warn_prod) / 40'd100);

    // =================================================================
    // next-state logic
    logic       above_lim;
    logic       above_warn;
    logic       brk_now;
    logic [4:0] ev;
    logic [31:0] lim_use;
    logic [31:0] warn_use;

    always_comb
    begin
        s_d = s_q;
        ev  = 5'h00;

        // =============================================================
        // limit refresh
        // refresh limits per reference sample
        if (ref_valid)
        begin
            s_d.limit    = lim_new;
            s_d.warn_thr = warn_new;
        end
        lim_use  = s_d.limit;
        warn_use = s_d.warn_thr;

        above_lim  = rc_value > lim_use;
        above_warn = rc_value > warn_use;

        // =============================================================
        // flag evaluation on each residual current sample
        if (rc_valid)
        begin
            if (above_warn && !s_q.flags.warn)
            begin
                ev[0] = 1'b1;
            end
            s_d.flags.warn = above_warn;
            if (above_lim && !s_q.flags.over)
            begin
                ev[1] = 1'b1;
            end
            s_d.flags.over = above_lim;
        end

        // =============================================================
        // exceedance timer and alarm
        // exceedance timer, restart on drop
        if (!s_d.flags.over)
        begin
            s_d.tcnt = 32'h0000_0000;
        end
        else if (s_q.tcnt <= s_q.tmin)
        begin
            // stops one past the minimum time
            s_d.tcnt = s_q.tcnt + 32'h0000_0001;
        end

        if (ack_pulse ||
            (reg_wr && reg_addr == `RCM_REG_ACK && reg_wdata[0]))
        begin
            s_d.flags.alarm = 1'b0;
        end
        if (s_d.flags.over && s_q.tcnt > s_q.tmin && !s_q.flags.alarm)
        begin
            s_d.flags.alarm = 1'b1;
            ev[2] = 1'b1;
        end

        // =============================================================
        // cable break
        // cable break check
        brk_now = s_q.ctrl.brk_en && |(mf_open_s_q & s_q.ctrl.brk_mf_en);
        if (brk_now && !s_q.flags.brk)
        begin
            ev[3] = 1'b1;
        end
        if (!brk_now && s_q.flags.brk)
        begin
            ev[4] = 1'b1;
        end
        s_d.flags.brk = brk_now;

        // =============================================================
        // register writes
        // unmapped addresses are ignored
        if (reg_wr)
        begin
            if (reg_addr == `RCM_REG_CTRL)
            begin
                s_d.ctrl.mode      = reg_wdata[1:0];
                s_d.ctrl.ref_sel   = reg_wdata[9:4];
                s_d.ctrl.brk_en    = reg_wdata[`RCM_CTRL_BRK_EN];
                s_d.ctrl.brk_mf_en = reg_wdata[19:16];
            end
            else if (reg_addr == `RCM_REG_STATIC)
            begin
                s_d.static_offset = reg_wdata;
            end
            else if (reg_addr == `RCM_REG_SCALE)
            begin
                s_d.scale = reg_wdata[15:0];
            end
            else if (reg_addr == `RCM_REG_WARN_PCT)
            begin
                s_d.warn_pct = reg_wdata[7:0];
            end
            else if (reg_addr == `RCM_REG_TMIN)
            begin
                s_d.tmin = reg_wdata;
            end
            else if (reg_addr == `RCM_REG_NSTEPS)
            begin
                if (reg_wdata[3:0] > 4'ha)
                begin
                    // a count above ten in bits 3:0 is clipped to ten
                    s_d.nsteps = 4'ha;
                end
                else
                begin
                    s_d.nsteps = reg_wdata[3:0];
                end
            end
            else if (reg_addr == `RCM_REG_IRQ_MASK)
            begin
                s_d.irq_mask = reg_wdata[4:0];
            end
            else if (reg_addr >= `RCM_REG_STEP_THR &&
                     reg_addr < `RCM_REG_STEP_THR + 8'h28)
            begin
                s_d.step_thresholds[4'(reg_addr[5:2])] = reg_wdata;
            end
            else if (reg_addr >= `RCM_REG_STEP_OFS &&
                     reg_addr < `RCM_REG_STEP_OFS + 8'h28)
            begin
                s_d.step_offsets[4'(reg_addr[5:2])] = reg_wdata;
            end
        end

        // =============================================================
        // sticky status: write one clears, set wins
        if (reg_wr && reg_addr == `RCM_REG_IRQ_STAT)
        begin
            s_d.irq_stat = s_q.irq_stat & ~reg_wdata[4:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;

        // =============================================================
        // read data, valid the cycle after the strobe
        // unmapped addresses read back zero
        s_d.rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            if (reg_addr == `RCM_REG_CTRL)
            begin
                s_d.rdata = {12'h000, s_q.ctrl.brk_mf_en, 3'h0,
                             s_q.ctrl.brk_en, 2'h0, s_q.ctrl.ref_sel,
                             2'h0, s_q.ctrl.mode};
            end
            else if (reg_addr == `RCM_REG_STATIC)
            begin
                s_d.rdata = s_q.static_offset;
            end
            else if (reg_addr == `RCM_REG_SCALE)
            begin
                s_d.rdata = {16'h0000, s_q.scale};
            end
            else if (reg_addr == `RCM_REG_WARN_PCT)
            begin
                s_d.rdata = {24'h00_0000, s_q.warn_pct};
            end
            else if (reg_addr == `RCM_REG_TMIN)
            begin
                s_d.rdata = s_q.tmin;
            end
            else if (reg_addr == `RCM_REG_NSTEPS)
            begin
                s_d.rdata = {28'h000_0000, s_q.nsteps};
            end
            else if (reg_addr == `RCM_REG_FLAGS)
            begin
                s_d.rdata = {28'h000_0000, s_q.flags.brk, s_q.flags.alarm,
                             s_q.flags.over, s_q.flags.warn};
            end
            else if (reg_addr == `RCM_REG_LIMIT)
            begin
                s_d.rdata = s_q.limit;
            end
            else if (reg_addr == `RCM_REG_WARN_THR)
            begin
                s_d.rdata = s_q.warn_thr;
            end
            else if (reg_addr == `RCM_REG_IRQ_STAT)
            begin
                s_d.rdata = {27'h000_0000, s_q.irq_stat};
            end
            else if (reg_addr == `RCM_REG_IRQ_MASK)
            begin
                s_d.rdata = {27'h000_0000, s_q.irq_mask};
            end
            else if (reg_addr >= `RCM_REG_STEP_THR &&
                     reg_addr < `RCM_REG_STEP_THR + 8'h28)
            begin
                s_d.rdata = s_q.step_thresholds[4'(reg_addr[5:2])];
            end
            else if (reg_addr >= `RCM_REG_STEP_OFS &&
                     reg_addr < `RCM_REG_STEP_OFS + 8'h28)
            begin
                s_d.rdata = s_q.step_offsets[4'(reg_addr[5:2])];
            end
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q      <= '0;
            s_q.tmin <= `RCM_ALARM_TMIN_RST;
        end
        else
            s_q <= s_d;
    end

    // =================================================================
    // outputs
    assign reg_rdata  = s_q.rdata;
    assign warn_flag  = s_q.flags.warn;
    assign over_flag  = s_q.flags.over;
    assign alarm_flag = s_q.flags.alarm;
    assign brk_flag   = s_q.flags.brk;
    assign irq        = |(s_q.irq_stat & s_q.irq_mask);

endmodule : rcm_monitor
`default_nettype wire

// File: hw/rcm_pkg.sv
package rcm_pkg;

    typedef enum logic [1:0] {
        RCM_MODE_STATIC,
        RCM_MODE_DYNAMIC,
        RCM_MODE_STEPWISE
    } rcm_mode_t;

    typedef struct packed {
        logic [1:0]  mode;
        logic [5:0]  ref_sel;
        logic        brk_en;
        logic [3:0]  brk_mf_en;
    } rcm_ctrl_t;

    typedef struct packed {
        logic        warn;
        logic        over;
        logic        alarm;
        logic        brk;
    } rcm_flags_t;

    typedef struct packed {
        rcm_ctrl_t              ctrl;
        logic [31:0]            static_offset;
        logic [15:0]            scale;
        logic [7:0]             warn_pct;
        logic [31:0]            tmin;
        logic [3:0]             nsteps;
        logic [9:0][31:0]       step_thresholds;
        logic [9:0][31:0]       step_offsets;
        logic [31:0]            limit;
        logic [31:0]            warn_thr;
        logic [31:0]            tcnt;
        rcm_flags_t             flags;
        logic [4:0]             irq_stat;
        logic [4:0]             irq_mask;
        logic [31:0]            rdata;
    } rcm_state_t;

endpackage : rcm_pkg

// File: test/rcm_chk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defs.svh"
// =====
// port checker
module rcm_checker
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        ack_pulse,
    input wire logic        rc_valid_seen,
    input wire logic        warn_flag,
    input wire logic        over_flag,
    input wire logic        alarm_flag,
    input wire logic        brk_flag
);
    logic [31:0] tmin_q;
    logic [31:0] ocnt_q;
    logic        brk_en_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // shadow of the alarm time and break enable, run length of over
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tmin_q   <= `RCM_ALARM_TMIN_RST;
            brk_en_q <= 1'b0;
            ocnt_q   <= 32'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == `RCM_REG_TMIN)
                tmin_q <= reg_wdata;
            if (reg_wr && reg_addr == `RCM_REG_CTRL)
                brk_en_q <= reg_wdata[`RCM_CTRL_BRK_EN];
            ocnt_q <= over_flag ? ocnt_q + 32'h1 : 32'h0;
        end
    end
    sequence s_flag_read;
        reg_rd && reg_addr == `RCM_REG_FLAGS
        ##1 $stable({brk_flag, alarm_flag, over_flag, warn_flag});
    endsequence
    sequence s_no_ack;
        !ack_pulse && !(reg_wr && reg_addr == `RCM_REG_ACK);
    endsequence
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    property p_rdata_flags;
        s_flag_read |-> reg_rdata[3:0] ==
            {brk_flag, alarm_flag, over_flag, warn_flag};
    endproperty
    property p_flag_cause;
        $changed({warn_flag, over_flag}) |-> $past(rc_valid_seen);
    endproperty
    property p_alarm_hold;
        (alarm_flag and s_no_ack) |=> alarm_flag;
    endproperty
    property p_ack_clear;
        ack_pulse && alarm_flag |=> !alarm_flag;
    endproperty
    property p_alarm_min;
        $rose(alarm_flag) |-> ocnt_q > tmin_q;
    endproperty
    property p_alarm_max;
        ocnt_q == tmin_q + 32'h4 |-> alarm_flag;
    endproperty
    property p_brk_en;
        $rose(brk_flag) |-> brk_en_q;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");
    a_rdata_flags: assert property (p_rdata_flags)
        else $error("flag readback");
    a_flag_cause: assert property (p_flag_cause)
        else $error("flag without sample");
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm lost");
    a_ack_clear: assert property (p_ack_clear)
        else $error("ack ignored");
    a_alarm_min: assert property (p_alarm_min)
        else $error("alarm early");
    a_alarm_max: assert property (p_alarm_max)
        else $error("alarm late");
    a_brk_en: assert property (p_brk_en)
        else $error("break while off");
endmodule : rcm_checker
bind rcm_monitor rcm_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ack_pulse(ack_pulse), .warn_flag(warn_flag),
    .over_flag(over_flag), .alarm_flag(alarm_flag), .brk_flag(brk_flag),
    .rc_valid_seen(rc_valid)
);
`default_nettype wire

// File: test/rcm_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// measurement front end
module rcm_front_model
(
    input  wire logic          sys_clk,
    output logic [31:0]        rc_value,
    output logic               rc_valid,
    output logic [63:0][15:0]  ref_values,
    output logic               ref_valid,
    output logic [3:0]         mf_open
);
    initial
    begin
        rc_value   = 32'h0;
        rc_valid   = 1'b0;
        ref_values = '0;
        ref_valid  = 1'b0;
        mf_open    = 4'h0;
    end
    task automatic rc_sample(input logic [31:0] v);
        @(posedge sys_clk);
        rc_value <= v;
        rc_valid <= 1'b1;
        @(posedge sys_clk);
        rc_valid <= 1'b0;
        rc_value <= ~v;
    endtask : rc_sample
    task automatic ref_sample(input int ch, input logic [15:0] v);
        @(posedge sys_clk);
        ref_values[ch] <= v;
        ref_valid      <= 1'b1;
        @(posedge sys_clk);
        ref_valid      <= 1'b0;
    endtask : ref_sample
    task automatic set_open(input logic [3:0] m);
        @(posedge sys_clk);
        mf_open <= m;
    endtask : set_open
endmodule : rcm_front_model
`default_nettype wire

// File: test/rcm_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defs.svh"
// =====
// testbench
module rcm_monitor_test;
    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic [7:0]        reg_addr = 8'h0;
    logic [31:0]       reg_wdata = 32'h0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              ack_pulse = 1'b0;
    logic [31:0]       reg_rdata, rc_value;
    logic              rc_valid, ref_valid, irq;
    logic              warn_flag, over_flag, alarm_flag, brk_flag;
    logic [63:0][15:0] ref_values;
    logic [3:0]        mf_open;
    int                n_errors = 0;
    int                total_checks = 0;
    logic [31:0] sv [6] = '{32'h320, 32'h321, 32'h3e8,
                            32'h3e9, 32'h3e8, 32'h320};
    logic [3:0]  se [6] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h1, 4'h0};
    logic [31:0] st [3] = '{32'h64, 32'hc8, 32'h12c};
    logic [31:0] so [3] = '{32'h32, 32'h1f4, 32'ha};
    logic [15:0] rv [6] = '{16'h32, 16'h64, 16'h96,
                            16'hfa, 16'h12c, 16'h15e};
    logic [31:0] rl [6] = '{32'h14, 32'h14, 32'h46,
                            32'h208, 32'h208, 32'h1e};
    always #20 sys_clk = ~sys_clk;
    rcm_monitor u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rc_value(rc_value), .rc_valid(rc_valid),
        .ref_values(ref_values), .ref_valid(ref_valid), .mf_open(mf_open),
        .ack_pulse(ack_pulse), .warn_flag(warn_flag), .over_flag(over_flag),
        .alarm_flag(alarm_flag), .brk_flag(brk_flag), .irq(irq)
    );
    rcm_front_model u_fe (
        .sys_clk(sys_clk), .rc_value(rc_value), .rc_valid(rc_valid),
        .ref_values(ref_values), .ref_valid(ref_valid), .mf_open(mf_open)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic rc(input logic [31:0] v, input logic [3:0] e);
        u_fe.rc_sample(v);
        #1 chk({28'h0, brk_flag, alarm_flag, over_flag, warn_flag}, {28'h0, e});
    endtask : rc
    task automatic wait_brk(input logic e);
        for (int k = 0; k < 10 && brk_flag !== e; k++)
            @(posedge sys_clk);
        #1 chk({31'h0, brk_flag}, {31'h0, e});
    endtask : wait_brk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`RCM_REG_TMIN, `RCM_ALARM_TMIN_RST);
        rd(`RCM_REG_FLAGS, 32'h0);
        rd(8'hfc, 32'h0);
        $display("test reset done");
        wr(`RCM_REG_STATIC, 32'h3e8);
        wr(`RCM_REG_WARN_PCT, 32'h50);
        u_fe.ref_sample(0, 16'h0);
        rd(`RCM_REG_LIMIT, 32'h3e8);
        rd(`RCM_REG_WARN_THR, 32'h320);
        foreach (sv[i])
            rc(sv[i], se[i]);
        $display("test static done");
        wr(`RCM_REG_IRQ_STAT, 32'h1f);
        wr(`RCM_REG_TMIN, 32'h8);
        rc(32'h3e9, 4'h3);
        repeat (4) @(posedge sys_clk);
        rc(32'h0, 4'h0);
        rc(32'h3e9, 4'h3);
        repeat (12) @(posedge sys_clk);
        rc(32'h0, 4'h4);
        rd(`RCM_REG_IRQ_STAT, 32'h7);
        wr(`RCM_REG_IRQ_MASK, 32'h4);
        #1 chk({31'h0, irq}, 32'h1);
        wr(`RCM_REG_IRQ_MASK, 32'h0);
        #1 chk({31'h0, irq}, 32'h0);
        @(posedge sys_clk);
        ack_pulse <= 1'b1;
        @(posedge sys_clk);
        ack_pulse <= 1'b0;
        #1 chk({31'h0, alarm_flag}, 32'h0);
        wr(`RCM_REG_IRQ_STAT, 32'h1f);
        rd(`RCM_REG_IRQ_STAT, 32'h0);
        $display("test alarm done");
        wr(`RCM_REG_CTRL, 32'h51);
        wr(`RCM_REG_SCALE, 32'ha);
        wr(`RCM_REG_STATIC, 32'h14);
        u_fe.ref_sample(5, 16'h1e);
        u_fe.ref_sample(3, 16'h3e7);
        rd(`RCM_REG_LIMIT, 32'h140);
        rd(`RCM_REG_WARN_THR, 32'h100);
        rc(32'h141, 4'h3);
        rc(32'h0, 4'h0);
        $display("test dynamic done");
        wr(`RCM_REG_CTRL, 32'h52);
        wr(`RCM_REG_NSTEPS, 32'h0);
        u_fe.ref_sample(5, 16'h1f4);
        rd(`RCM_REG_LIMIT, 32'h14);
        for (int i = 0; i < 3; i++)
        begin
            wr(`RCM_REG_STEP_THR + 8'(4 * i), st[i]);
            wr(`RCM_REG_STEP_OFS + 8'(4 * i), so[i]);
        end
        wr(`RCM_REG_NSTEPS, 32'h3);
        foreach (rv[i])
        begin
            u_fe.ref_sample(5, rv[i]);
            rd(`RCM_REG_LIMIT, rl[i]);
        end
        $display("test stepwise done");
        wr(`RCM_REG_CTRL, 32'h11000);
        u_fe.set_open(4'h1);
        wait_brk(1'b1);
        rd(`RCM_REG_IRQ_STAT, 32'hb);
        u_fe.set_open(4'h0);
        wait_brk(1'b0);
        rd(`RCM_REG_IRQ_STAT, 32'h1b);
        $display("test break done");
        wrap_up();
    end
endmodule : rcm_monitor_test
`default_nettype wire
